// ---- src/gdi_device_interface.sv ----
`timescale 1ns/100ps

// Overview of operation
// - Interface clear drops addressing, keeps queues, aborts command decoding.
// - Interface clear ends bus traffic without any device clear.
// - Keycode or mnemonic error sets status bit 0 and error bit 5.
// - Lockout by another module sets status bit 1 and error bit.
// - Panel use while remote without lockout sets bit 2, error bit, and goes local.
// - Status updates are ORed into the existing status byte.
// - Status bits other than data-ready and service request clear only on DCL or SDC from the controller.
// - Data-ready bit clears once all available output data is read.
// - Service request released with data-ready clear if no error remains.
// - DCL acts like SDC with menu, transient and mode exceptions.
// - Remote enable plus own listen address puts device remote.
// - GTL while addressed to listen returns device to local.
// - LLO enters lockout only while remote enable is true.
// - Remote enable going false forces local and leaves lockout.
// - SRQ line asserted while service is needed, released otherwise.
// - Serial poll sends status byte, bit 6 flags service request.
// - PPC arms parallel poll programming by the next command.
// - PPE programs poll line and sense only right after PPC.
// - PPD disables poll response only right after PPC.
// - PPU always disables the parallel poll response.
// - Parallel poll drives service status on assigned line, else passive.
// - Own listen address makes the device listener active.
// - Own talk address makes talker active, other address drops it.
module gdi_device_interface (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_my_addr,
  input wire logic i_atn,
  input wire logic i_ifc,
  input wire logic i_ren,
  input wire logic i_eoi,
  input wire logic [7:0] i_dio,
  output logic [7:0] o_dio,
  output logic [7:0] o_dio_oe_n,
  input wire logic i_dav,
  output logic o_dav,
  output logic o_dav_oe_n,
  input wire logic i_nrfd,
  output logic o_nrfd,
  output logic o_nrfd_oe_n,
  input wire logic i_ndac,
  output logic o_ndac,
  output logic o_ndac_oe_n,
  output logic o_srq,
  output logic o_srq_oe_n,
  input wire logic i_out_valid,
  input wire logic [7:0] i_out_data,
  input wire logic i_out_last,
  output logic o_out_take,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_eoi,
  input wire logic i_err_keycode,
  input wire logic i_err_kicked,
  input wire logic i_panel_access,
  input wire logic i_pon_fail,
  input wire logic i_dev_fail,
  input wire logic i_data_ready,
  input wire logic i_srq_on_ready,
  output logic [7:0] o_service_poll_status,
  output logic o_remote,
  output logic o_lockout,
  output logic o_listening,
  output logic o_talking,
  output logic o_sdc,
  output logic o_dcl,
  output logic o_cmd_abort
);

  // ==========================================================
  // State.
  gdi_pkg::gdi_ah_e ah_r, ah_nxt;
  gdi_pkg::gdi_sh_e sh_r, sh_nxt;
  logic lad_r, lad_nxt;
  logic tad_r, tad_nxt;
  logic spe_r, spe_nxt;
  logic rem_r, rem_nxt;
  logic lls_r, lls_nxt;
  logic ppc_r, ppc_nxt;
  logic ppe_r, ppe_nxt;
  logic pp_sense_r, pp_sense_nxt;
  logic [2:0] pp_line_r, pp_line_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic srq_r, srq_nxt;
  logic [7:0] sh_byte_r, sh_byte_nxt;
  logic sh_poll_r, sh_poll_nxt;
  logic rx_valid_r;
  logic [7:0] rx_data_r;
  logic rx_eoi_r;
  logic sdc_r;
  logic dcl_r;
  logic abort_r;

  // ==========================================================
  // Acceptor handshake and command decode.
  logic [6:0] cmd;
  logic accept_en;
  logic take;
  logic cmd_stb;
  logic data_stb;
  logic is_lad;
  logic is_tad;
  logic my_lad;
  logic my_tad;
  logic is_ppe;
  logic sdc_stb;
  logic dcl_stb;
  logic gtl_stb;
  logic pp_active;
  logic panel_hit;

  assign cmd = i_dio[6:0];
  assign accept_en = i_atn | (lad_r & ~tad_r);
  assign take = (ah_r == gdi_pkg::AH_READY) & i_dav & accept_en & ~i_ifc;
  assign cmd_stb = take & i_atn;
  assign data_stb = take & ~i_atn & lad_r;
  assign is_lad = (cmd[6:5] == gdi_pkg::GRP_LISTEN) & (cmd != gdi_pkg::CMD_UNL);
  assign is_tad = (cmd[6:5] == gdi_pkg::GRP_TALK) & (cmd != gdi_pkg::CMD_UNT);
  assign my_lad = cmd_stb & is_lad & (cmd[4:0] == i_my_addr);
  assign my_tad = is_tad & (cmd[4:0] == i_my_addr);
  assign is_ppe = cmd[6:4] == gdi_pkg::GRP_PPE;
  assign sdc_stb = cmd_stb & lad_r & (cmd == gdi_pkg::CMD_SDC);
  assign dcl_stb = cmd_stb & (cmd == gdi_pkg::CMD_DCL);
  assign gtl_stb = cmd_stb & lad_r & (cmd == gdi_pkg::CMD_GTL);
  assign pp_active = i_atn & i_eoi;

  always_comb begin
    ah_nxt = ah_r;
    unique case (ah_r)
      gdi_pkg::AH_READY: begin
        if (take) begin
          ah_nxt = gdi_pkg::AH_HOLD;
        end
      end
      gdi_pkg::AH_HOLD: begin
        if (!i_dav || i_ifc) begin
          ah_nxt = gdi_pkg::AH_READY;
        end
      end
      default: begin
        ah_nxt = gdi_pkg::AH_READY;
      end
    endcase
  end

  // ==========================================================
  // Addressing, remote state and parallel poll setup.
  always_comb begin
    lad_nxt = lad_r;
    tad_nxt = tad_r;
    spe_nxt = spe_r;
    rem_nxt = rem_r;
    lls_nxt = lls_r;
    ppc_nxt = ppc_r;
    ppe_nxt = ppe_r;
    pp_sense_nxt = pp_sense_r;
    pp_line_nxt = pp_line_r;
    if (cmd_stb) begin
      ppc_nxt = 1'b0;
      if (my_lad) begin
        lad_nxt = 1'b1;
        if (i_ren) begin
          rem_nxt = 1'b1;
        end
      end
      if (cmd == gdi_pkg::CMD_UNL) begin
        lad_nxt = 1'b0;
      end
      if (is_tad) begin
        tad_nxt = my_tad;
      end
      if (cmd == gdi_pkg::CMD_UNT) begin
        tad_nxt = 1'b0;
      end
      if (cmd == gdi_pkg::CMD_SPE) begin
        spe_nxt = 1'b1;
      end
      if (cmd == gdi_pkg::CMD_SPD) begin
        spe_nxt = 1'b0;
      end
      if (gtl_stb) begin
        rem_nxt = 1'b0;
      end
      if (cmd == gdi_pkg::CMD_LLO && i_ren) begin
        lls_nxt = 1'b1;
      end
      if (lad_r && cmd == gdi_pkg::CMD_PPC) begin
        ppc_nxt = 1'b1;
      end
      if (ppc_r && is_ppe) begin
        ppe_nxt = 1'b1;
        pp_sense_nxt = cmd[3];
        pp_line_nxt = cmd[2:0];
      end
      if (ppc_r && cmd == gdi_pkg::CMD_PPD) begin
        ppe_nxt = 1'b0;
      end
      if (cmd == gdi_pkg::CMD_PPU) begin
        ppe_nxt = 1'b0;
      end
    end
    if (panel_hit) begin
      rem_nxt = 1'b0;
    end
    // Addressing, serial poll mode and a pending PPC are dropped; parallel poll setup survives.
    if (i_ifc) begin
      lad_nxt = 1'b0;
      tad_nxt = 1'b0;
      spe_nxt = 1'b0;
      ppc_nxt = 1'b0;
    end
    if (!i_ren) begin
      rem_nxt = 1'b0;
      lls_nxt = 1'b0;
    end
  end

  // ==========================================================
  // Service poll status.
  logic ready_done;
  logic dev_clear;
  logic err_set;
  logic [7:0] set_bits;
  logic [7:0] kept_bits;

  // With lockout active the panel is inhibited, so no override occurs.
  assign panel_hit = i_panel_access & rem_r & ~lls_r;
  assign ready_done = o_out_take & i_out_last;
  assign dev_clear = sdc_stb | dcl_stb;
  assign err_set = i_err_keycode | i_err_kicked | panel_hit | i_dev_fail;
  assign set_bits = {i_pon_fail | i_dev_fail, 1'b0, err_set,
                     i_data_ready, 1'b0, panel_hit,
                     i_err_kicked, i_err_keycode};
  assign kept_bits = dev_clear ? gdi_pkg::STATUS_RESET : stat_r;

  always_comb begin
    stat_nxt = kept_bits;
    if (ready_done) begin
      stat_nxt[gdi_pkg::ST_READY] = 1'b0;
    end
    stat_nxt = stat_nxt | set_bits;
    srq_nxt = srq_r;
    if (dev_clear) begin
      srq_nxt = 1'b0;
    end else if (ready_done && !stat_r[gdi_pkg::ST_ERR]) begin
      srq_nxt = 1'b0;
    end
    if (err_set || (i_data_ready && i_srq_on_ready)) begin
      srq_nxt = 1'b1;
    end
  end

  logic [7:0] status_byte;
  assign status_byte = stat_r | {1'b0, srq_r, 6'h00};

  // ==========================================================
  // Source handshake for talker data and serial poll.
  logic sh_start;
  assign sh_start = tad_r & ~i_atn & (spe_r | i_out_valid);

  always_comb begin
    sh_nxt = sh_r;
    sh_byte_nxt = sh_byte_r;
    sh_poll_nxt = sh_poll_r;
    unique case (sh_r)
      gdi_pkg::SH_IDLE: begin
        if (sh_start) begin
          sh_nxt = gdi_pkg::SH_WAIT_RFD;
          sh_poll_nxt = spe_r;
          sh_byte_nxt = spe_r ? status_byte : i_out_data;
        end
      end
      gdi_pkg::SH_WAIT_RFD: begin
        if (!i_nrfd) begin
          sh_nxt = gdi_pkg::SH_WAIT_ACC;
        end
      end
      gdi_pkg::SH_WAIT_ACC: begin
        if (!i_ndac) begin
          sh_nxt = gdi_pkg::SH_IDLE;
        end
      end
      default: begin
        sh_nxt = gdi_pkg::SH_IDLE;
      end
    endcase
    // Attention or clear from the controller cuts a byte short.
    if (i_atn || i_ifc || !tad_r) begin
      sh_nxt = gdi_pkg::SH_IDLE;
    end
  end

  assign o_out_take = (sh_r == gdi_pkg::SH_WAIT_ACC) & ~i_ndac & ~sh_poll_r
                      & ~i_atn & ~i_ifc & tad_r;

  // ==========================================================
  // Registers.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ah_r <= gdi_pkg::AH_READY;
      sh_r <= gdi_pkg::SH_IDLE;
      lad_r <= 1'b0;
      tad_r <= 1'b0;
      spe_r <= 1'b0;
      rem_r <= 1'b0;
      lls_r <= 1'b0;
      ppc_r <= 1'b0;
      ppe_r <= 1'b0;
      pp_sense_r <= 1'b0;
      pp_line_r <= gdi_pkg::PP_LINE_RESET;
      stat_r <= gdi_pkg::STATUS_RESET;
      srq_r <= 1'b0;
      sh_byte_r <= 8'h00;
      sh_poll_r <= 1'b0;
    end else begin
      ah_r <= ah_nxt;
      sh_r <= sh_nxt;
      lad_r <= lad_nxt;
      tad_r <= tad_nxt;
      spe_r <= spe_nxt;
      rem_r <= rem_nxt;
      lls_r <= lls_nxt;
      ppc_r <= ppc_nxt;
      ppe_r <= ppe_nxt;
      pp_sense_r <= pp_sense_nxt;
      pp_line_r <= pp_line_nxt;
      stat_r <= stat_nxt;
      srq_r <= srq_nxt;
      sh_byte_r <= sh_byte_nxt;
      sh_poll_r <= sh_poll_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_valid_r <= 1'b0;
      rx_data_r <= 8'h00;
      rx_eoi_r <= 1'b0;
      sdc_r <= 1'b0;
      dcl_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      rx_valid_r <= data_stb;
      if (data_stb) begin
        rx_data_r <= i_dio;
        rx_eoi_r <= i_eoi;
      end
      sdc_r <= sdc_stb;
      dcl_r <= dcl_stb;
      abort_r <= i_ifc;
    end
  end

  // ==========================================================
  // Bus drivers; an enable low means this end pulls the line.
  logic talk_drive;
  logic pp_hit;
  logic [7:0] pp_mask;

  assign talk_drive = (sh_r != gdi_pkg::SH_IDLE) & ~i_atn;
  assign pp_hit = pp_active & ppe_r & (srq_r == pp_sense_r);
  assign pp_mask = 8'h01 << pp_line_r;

  assign o_dio = talk_drive ? sh_byte_r : pp_mask;
  assign o_dio_oe_n = talk_drive ? 8'h00 : (pp_hit ? ~pp_mask : 8'hff);
  assign o_dav = 1'b1;
  assign o_dav_oe_n = ~(sh_r == gdi_pkg::SH_WAIT_ACC & ~i_atn);
  assign o_nrfd = 1'b1;
  assign o_nrfd_oe_n = ~(accept_en & ah_r == gdi_pkg::AH_HOLD);
  assign o_ndac = 1'b1;
  assign o_ndac_oe_n = ~(accept_en & ah_r == gdi_pkg::AH_READY);
  assign o_srq = 1'b1;
  assign o_srq_oe_n = ~srq_r;

  assign o_rx_valid = rx_valid_r;
  assign o_rx_data = rx_data_r;
  assign o_rx_eoi = rx_eoi_r;
  assign o_service_poll_status = status_byte;
  assign o_remote = rem_r;
  assign o_lockout = lls_r;
  assign o_listening = lad_r;
  assign o_talking = tad_r;
  assign o_sdc = sdc_r;
  assign o_dcl = dcl_r;
  assign o_cmd_abort = abort_r;

endmodule : gdi_device_interface

// ---- src/gdi_pkg.sv ----
package gdi_pkg;

  // ==========================================================
  // Interface command bytes, parity bit stripped.
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [6:0] CMD_PPD = 7'h70;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [2:0] GRP_PPE = 3'h6;

  // ==========================================================
  // Service poll status field positions.
  localparam int ST_KEYCODE = 0;
  localparam int ST_KICKED = 1;
  localparam int ST_PANEL = 2;
  localparam int ST_READY = 4;
  localparam int ST_ERR = 5;
  localparam int ST_RQS = 6;
  localparam int ST_PON = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] PP_LINE_RESET = 3'h0;

  // ==========================================================
  // Handshake state machines.
  typedef enum logic [1:0] {
    AH_READY,
    AH_HOLD
  } gdi_ah_e;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_WAIT_RFD,
    SH_WAIT_ACC
  } gdi_sh_e;

endpackage : gdi_pkg

// ---- test/gdi_checker.sv ----
`timescale 1ns/100ps
// ==========================================================
// Port checks for the device interface.
module gdi_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_atn,
  input wire logic i_ifc,
  input wire logic i_ren,
  input wire logic i_eoi,
  input wire logic i_err_keycode,
  input wire logic i_err_kicked,
  input wire logic i_panel_access,
  input wire logic [7:0] o_dio_oe_n,
  input wire logic o_srq_oe_n,
  input wire logic o_out_take,
  input wire logic [7:0] o_service_poll_status,
  input wire logic o_remote,
  input wire logic o_lockout,
  input wire logic o_listening,
  input wire logic o_talking,
  input wire logic o_sdc,
  input wire logic o_dcl,
  input wire logic o_cmd_abort
);
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  logic [7:0] st;
  logic clr;
  assign st = o_service_poll_status;
  assign clr = o_sdc || o_dcl;

  a_ifc_unaddress: assert property (
    i_ifc |=> !o_listening && !o_talking && o_cmd_abort)
    else $error("ifc left device addressed");
  a_ren_local: assert property (!i_ren |=> !o_remote && !o_lockout)
    else $error("ren low but not local");
  a_keycode_bits: assert property (i_err_keycode |=> st[0] && st[5])
    else $error("keycode error bits missing");
  a_kicked_bits: assert property (i_err_kicked |=> st[1] && st[5])
    else $error("kicked bits missing");
  a_panel_local: assert property (
    i_panel_access && o_remote && !o_lockout |=> st[2] && st[5] && !o_remote)
    else $error("panel access in remote mishandled");
  a_status_sticky: assert property (
    $past(i_resetn) && |($past(st) & ~st & 8'haf) |-> clr || $past(clr))
    else $error("status bit dropped without clear");
  a_ready_drop: assert property (
    $past(i_resetn) && $fell(st[4]) |-> $past(o_out_take) || clr || $past(clr))
    else $error("ready bit dropped without read");
  a_srq_line: assert property (o_srq_oe_n == !st[6])
    else $error("srq line disagrees with status");
  a_lockout_ren: assert property ($rose(o_lockout) |-> $past(i_ren))
    else $error("lockout without ren");
  a_dio_idle: assert property (
    !o_talking && !$past(o_talking) && !(i_atn && i_eoi) |-> &o_dio_oe_n)
    else $error("data lines driven while idle");

  c_serial_poll: cover property (o_talking && !i_atn && !(&o_dio_oe_n));
  c_par_poll: cover property (i_atn && i_eoi && !(&o_dio_oe_n));
  c_sdc: cover property (o_sdc);
  c_dcl: cover property (o_dcl);
endmodule : gdi_checker

bind gdi_device_interface gdi_checker gdi_checker_inst (
  .i_clk, .i_resetn, .i_atn, .i_ifc, .i_ren, .i_eoi, .i_err_keycode,
  .i_err_kicked, .i_panel_access, .o_dio_oe_n, .o_srq_oe_n, .o_out_take,
  .o_service_poll_status, .o_remote, .o_lockout, .o_listening,
  .o_talking, .o_sdc, .o_dcl, .o_cmd_abort
);

// ---- test/gdi_ctrl_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// Bus controller model: source and acceptor handshakes.
module gdi_ctrl_model (
  input wire logic i_clk,
  input wire logic i_nrfd,
  input wire logic i_ndac,
  input wire logic i_dav,
  input wire logic [7:0] i_dio,
  output logic o_atn,
  output logic o_ren,
  output logic o_eoi,
  output logic o_ifc,
  output logic o_dav,
  output logic o_nrfd,
  output logic o_ndac,
  output logic [7:0] o_dio,
  output logic o_hung
);
  int lag = 0;
  initial begin
    {o_atn, o_ren, o_eoi, o_ifc, o_dav, o_nrfd, o_ndac} = 7'h00;
    o_dio = 8'h00;
    o_hung = 1'b0;
  end
  // Bits are atn, ren, eoi, ifc; the last one holds off a talker.
  task automatic lines(input logic [4:0] v);
    @(posedge i_clk);
    {o_atn, o_ren, o_eoi, o_ifc} <= v[4:1];
    {o_nrfd, o_ndac} <= {2{v[0]}};
  endtask : lines
  // Always lets one edge pass, so no line is assigned twice at once.
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while ((s == 0 ? i_nrfd : s == 1 ? i_ndac : i_dav) !== v && n < 400);
    if (n == 400) o_hung <= 1'b1;
  endtask : wt
  // Released data lines read false, as the pull-ups leave them.
  task automatic put(input logic [7:0] b);
    wt(0, 1'b0);
    repeat (lag) @(posedge i_clk);
    o_dio <= b;
    @(posedge i_clk);
    o_dav <= 1'b1;
    wt(1, 1'b0);
    o_dav <= 1'b0;
    o_dio <= 8'h00;
  endtask : put
  task automatic get(output logic [7:0] b);
    repeat (lag + 1) @(posedge i_clk);
    o_nrfd <= 1'b0;
    wt(2, 1'b1);
    b = i_dio;
    o_nrfd <= 1'b1;
    o_ndac <= 1'b0;
    wt(2, 1'b0);
    o_ndac <= 1'b1;
  endtask : get
endmodule : gdi_ctrl_model

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] my;
  logic [2:0] pl;
  logic [6:0] la, ta;
  logic [7:0] d, b, rx, xs, cdio, bdio, dv, doe, rxd, st;
  logic [5:0] ev = 6'h00;
  logic ov = 1'b0;
  logic last = 1'b1;
  logic sor = 1'b0;
  logic sdc_seen = 1'b0;
  logic dcl_seen = 1'b0;
  logic atn, ifc, ren, eoi, cdav, cnrfd, cndac, hung, bdav, bnrfd, bndac;
  logic davn, nrfdn, ndacn, srqn, take, rxv, remote, lock, lis, tlk, sdc;
  logic dcl;
  logic odav, onrfd, ondac, osrq, rxe, abrt;
  int errors = 0;
  int n_tests = 0;
  int k;

  always #50 clk = ~clk;
  assign bdio = cdio | (dv & ~doe);
  assign bdav = cdav | ~davn;
  assign bnrfd = cnrfd | ~nrfdn;
  assign bndac = cndac | ~ndacn;

  gdi_ctrl_model gdi_ctrl_model_inst (
    .i_clk(clk), .i_nrfd(bnrfd), .i_ndac(bndac), .i_dav(bdav),
    .i_dio(bdio), .o_atn(atn), .o_ren(ren), .o_eoi(eoi), .o_ifc(ifc),
    .o_dav(cdav), .o_nrfd(cnrfd), .o_ndac(cndac), .o_dio(cdio),
    .o_hung(hung)
  );
  gdi_device_interface gdi_device_interface_inst (
    .i_clk(clk), .i_resetn(resetn), .i_my_addr(my), .i_atn(atn),
    .i_ifc(ifc), .i_ren(ren), .i_eoi(eoi), .i_dio(bdio), .o_dio(dv),
    .o_dio_oe_n(doe), .i_dav(bdav), .o_dav(odav), .o_dav_oe_n(davn),
    .i_nrfd(bnrfd), .o_nrfd(onrfd), .o_nrfd_oe_n(nrfdn), .i_ndac(bndac),
    .o_ndac(ondac), .o_ndac_oe_n(ndacn), .o_srq(osrq), .o_srq_oe_n(srqn),
    .i_out_valid(ov), .i_out_data(b), .i_out_last(last),
    .o_out_take(take), .o_rx_valid(rxv), .o_rx_data(rxd), .o_rx_eoi(rxe),
    .i_err_keycode(ev[0]), .i_err_kicked(ev[1]), .i_panel_access(ev[2]),
    .i_pon_fail(ev[3]), .i_dev_fail(ev[4]), .i_data_ready(ev[5]),
    .i_srq_on_ready(sor), .o_service_poll_status(st), .o_remote(remote),
    .o_lockout(lock), .o_listening(lis), .o_talking(tlk), .o_sdc(sdc),
    .o_dcl(dcl), .o_cmd_abort(abrt)
  );

  always @(posedge clk) begin
    if (take) ov <= 1'b0;
    if (rxv) rx <= rxd;
    if (sdc) sdc_seen <= 1'b1;
    if (dcl) dcl_seen <= 1'b1;
  end

  // ==========================================================
  // Shared tasks.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %0t got %h want %h", $time, g, e);
      errors++;
    end
  endtask : chk
  task automatic cmd(input logic [6:0] c);
    gdi_ctrl_model_inst.put({1'b0, c});
    repeat (3) @(posedge clk);
  endtask : cmd
  task automatic evt(input int n);
    @(posedge clk);
    ev <= 6'h01 << n;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
  endtask : evt
  function automatic logic [7:0] ebits(input int n);
    return n == 0 ? 8'h61 : n == 1 ? 8'h62 : n == 3 ? 8'h80 : 8'he0;
  endfunction : ebits
  task automatic results;
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(32'he4ac));
    my = 5'($urandom % 31);
    pl = 3'($urandom);
    d = 8'($urandom);
    b = 8'($urandom);
    la = {gdi_pkg::GRP_LISTEN, my};
    ta = {gdi_pkg::GRP_TALK, my};
    gdi_ctrl_model_inst.lag = $urandom % 4;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(st, gdi_pkg::STATUS_RESET);
    chk(8'({remote, lock, lis, tlk, srqn, &doe}), 8'h03);
    chk(8'({odav, onrfd, ondac, osrq}), 8'h0f);
    gdi_ctrl_model_inst.lines(5'b11000);
    cmd(la);
    chk(8'({remote, lis}), 8'h03);
    cmd(gdi_pkg::CMD_GTL);
    chk(8'(remote), 8'h00);
    cmd(la);
    cmd(gdi_pkg::CMD_LLO);
    chk(8'({remote, lock}), 8'h03);
    gdi_ctrl_model_inst.lines(5'b10000);
    repeat (2) @(posedge clk);
    chk(8'({remote, lock}), 8'h00);
    gdi_ctrl_model_inst.lines(5'b11000);
    cmd(la);
    evt(2);
    chk(st, 8'h64);
    chk(8'({remote, srqn}), 8'h00);
    evt(0);
    chk(st, 8'h65);
    evt(1);
    chk(st, 8'h67);
    cmd(gdi_pkg::CMD_SPE);
    cmd(ta);
    gdi_ctrl_model_inst.lines(5'b01001);
    gdi_ctrl_model_inst.get(xs);
    chk(xs, 8'h67);
    gdi_ctrl_model_inst.lines(5'b11000);
    cmd(gdi_pkg::CMD_SPD);
    for (int j = 0; j < 5; j++) begin
      if (j != 1 && j != 2) cmd(gdi_pkg::CMD_PPC);
      if (j == 3) cmd({gdi_pkg::GRP_PPE, 1'b1, pl});
      if (j == 3) cmd(gdi_pkg::CMD_PPC);
      if (j == 1) cmd(gdi_pkg::CMD_PPU);
      else if (j == 3) cmd(gdi_pkg::CMD_PPD);
      else cmd({gdi_pkg::GRP_PPE, j != 4, pl});
      gdi_ctrl_model_inst.lines(5'b11100);
      repeat (2) @(posedge clk);
      chk(doe, j == 0 ? ~(8'h01 << pl) : 8'hff);
      gdi_ctrl_model_inst.lines(5'b11000);
    end
    xs = 8'h67;
    for (int i = 0; i < 6; i++) begin
      k = $urandom % 4;
      k = (k == 2) ? 4 : k;
      evt(k);
      xs = xs | ebits(k);
      chk(st, xs);
    end
    gdi_ctrl_model_inst.lines(5'b11010);
    repeat (2) @(posedge clk);
    chk(8'({lis, tlk, dcl_seen, abrt}), 8'h01);
    chk(st, xs);
    gdi_ctrl_model_inst.lines(5'b11000);
    cmd(la);
    cmd(gdi_pkg::CMD_SDC);
    chk(st, 8'h00);
    chk(8'({srqn, sdc_seen}), 8'h03);
    gdi_ctrl_model_inst.lines(5'b01100);
    gdi_ctrl_model_inst.put(d);
    repeat (3) @(posedge clk);
    chk(rx, d);
    chk(8'(rxe), 8'h01);
    gdi_ctrl_model_inst.lines(5'b11000);
    sor <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      if (j == 2) evt(0);
      if (j != 1) evt(5);
      chk(st, j == 2 ? 8'h71 : 8'h50);
      last <= (j != 0);
      b <= 8'($urandom);
      ov <= 1'b1;
      cmd(ta);
      gdi_ctrl_model_inst.lines(5'b01001);
      gdi_ctrl_model_inst.get(xs);
      chk(xs, b);
      repeat (2) @(posedge clk);
      chk(st, j == 0 ? 8'h50 : j == 1 ? 8'h00 : 8'h61);
      chk(8'(srqn), j == 1 ? 8'h01 : 8'h00);
      gdi_ctrl_model_inst.lines(5'b11000);
    end
    cmd(gdi_pkg::CMD_DCL);
    chk(st, 8'h00);
    chk(8'({dcl_seen, hung}), 8'h02);
    results();
  end
endmodule : tb_top
